/* File: rtl/scan_pin_pkg.sv */
`default_nettype none
package scan_pin_pkg;
	// tap controller states
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
	} tap_state_type;
	// apb register byte offsets
	localparam logic [11:0] CFG_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] USER_OUT_OFFSET = 12'h008;
	localparam logic [11:0] USER_OE_OFFSET = 12'h00c;
	localparam logic [11:0] USER_IN_OFFSET = 12'h010;
	// config field positions
	localparam int CFG_RESERVE_BIT = 0;
	localparam int CFG_TRST_BIT = 1;
	localparam int CFG_PULLUP_BIT = 2;
	localparam int CFG_PULLDN_BIT = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;
	// user pin bit positions: tdi, tck, tdo, trst
	localparam int PIN_TDI = 0;
	localparam int PIN_TCK = 1;
	localparam int PIN_TDO = 2;
	localparam int PIN_TRST = 3;
	localparam int NPINS = 4;
	// tms high cycles that guarantee return to reset
	localparam int TMS_RESET_CYCLES = 5;
endpackage : scan_pin_pkg
`default_nettype wire

/* File: rtl/tck_edge_if.sv */
`default_nettype none
interface tck_edge_if;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;
	modport src (output tck_rise, output tck_fall, output tms_s, output tdi_s);
	modport dst (input tck_rise, input tck_fall, input tms_s, input tdi_s);
endinterface : tck_edge_if
`default_nettype wire

/* File: rtl/tck_sampler.sv */
`default_nettype none
module tck_sampler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck_pin,
	input wire logic tms_pin,
	input wire logic tdi_pin,
	tck_edge_if.src edges
);
	logic [1:0] tck_sync_reg;
	logic [1:0] tms_sync_reg;
	logic [1:0] tdi_sync_reg;
	logic tck_last_reg;
	// two-stage synchronisers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tck_sync_reg <= 2'h0;
			tms_sync_reg <= 2'h3;
			tdi_sync_reg <= 2'h3;
			tck_last_reg <= 1'b0;
		end else begin
			tck_sync_reg <= {tck_sync_reg[0], tck_pin};
			tms_sync_reg <= {tms_sync_reg[0], tms_pin};
			tdi_sync_reg <= {tdi_sync_reg[0], tdi_pin};
			tck_last_reg <= tck_sync_reg[1];
		end
	end
	// edge detection on the second stage only
	assign edges.tck_rise = tck_sync_reg[1] & ~tck_last_reg;
	assign edges.tck_fall = ~tck_sync_reg[1] & tck_last_reg;
	assign edges.tms_s = tms_sync_reg[1];
	assign edges.tdi_s = tdi_sync_reg[1];
endmodule : tck_sampler
`default_nettype wire

/* File: rtl/tap_fsm.sv */
`default_nettype none
module tap_fsm
	import scan_pin_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic trst_active,
	tck_edge_if.dst edges,
	output tap_state_type state
);
	tap_state_type state_reg;
	tap_state_type state_next;
	// standard transition diagram
	// tms steered transitions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TLR: state_next = edges.tms_s ? TLR : RTI;
			RTI: state_next = edges.tms_s ? SEL_DR : RTI;
			SEL_DR: state_next = edges.tms_s ? SEL_IR : CAP_DR;
			CAP_DR: state_next = edges.tms_s ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: state_next = edges.tms_s ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: state_next = edges.tms_s ? UPD_DR : PAUSE_DR;
			PAUSE_DR: state_next = edges.tms_s ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: state_next = edges.tms_s ? UPD_DR : SHIFT_DR;
			UPD_DR: state_next = edges.tms_s ? SEL_DR : RTI;
			SEL_IR: state_next = edges.tms_s ? TLR : CAP_IR;
			CAP_IR: state_next = edges.tms_s ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: state_next = edges.tms_s ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: state_next = edges.tms_s ? UPD_IR : PAUSE_IR;
			PAUSE_IR: state_next = edges.tms_s ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: state_next = edges.tms_s ? UPD_IR : SHIFT_IR;
			UPD_IR: state_next = edges.tms_s ? SEL_DR : RTI;
			default: state_next = TLR;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b || trst_active) begin
			state_reg <= TLR;
		end else if (edges.tck_rise) begin
			state_reg <= state_next;
		end
	end
	assign state = state_reg;
endmodule : tap_fsm
`default_nettype wire

/* File: rtl/scan_pin_mode_control.sv */
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
// Summary of operation
// - All user pins float while the supplies are not yet good.
// - User pins stay tristated during power-up unless a pull-up or pull-down is selected.
// - The mode-select pin is never a user pin.
// - Dedicated mode keeps all scan pins for test with pull-ups on mode-select and data-in.
// - Flexible mode enables no pull on mode-select or data-in.
// - Flexible mode is the default until the reserve option is set.
// - The test state machine starts in its logic-reset state.
// - In flexible mode at logic-reset the shared pins are user pins.
// - A clock rise with mode-select low hands the shared pins to test until logic-reset.
// - With the reset option the reset pin is a test reset with a fixed pull-up.
// - Without the reset option the reset pin is a user pin, tristated when unused.
// - A low test reset forces the state machine into logic-reset.
module scan_pin_mode_control
	import scan_pin_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SUPPLY_GOOD,
	input wire logic [NPINS-1:0] PIN_IN,
	output logic [NPINS-1:0] PIN_OUT,
	output logic [NPINS-1:0] PIN_OE,
	input wire logic TMS_IN,
	output logic TMS_PULLUP,
	output logic TDI_PULLUP,
	output logic TRST_PULLUP,
	output logic [NPINS-1:0] PIN_PULLUP,
	output logic [NPINS-1:0] PIN_PULLDN,
	output logic SCAN_ACTIVE,
	input wire logic SCAN_TDO,
	input wire logic [31:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	tck_edge_if edges ();
	tap_state_type tap_state;
	logic [3:0] cfg_reg;
	logic [NPINS-1:0] uout_reg;
	logic [NPINS-1:0] uoe_reg;
	logic [NPINS-1:0] uin_reg;
	logic [NPINS-1:0] uin_meta_reg;
	logic [1:0] trst_sync_reg;
	logic [1:0] good_sync_reg;
	logic [1:0] tdo_sync_reg;
	logic scan_own_reg;
	logic trst_active;
	logic dedicated;
	logic trst_mode;
	logic powered;
	logic apb_access;
	logic addr_ok;
	logic [NPINS-1:0] oe_next;
	logic [NPINS-1:0] out_next;
	logic [2:0] tms_high_cnt;

	// config fields
	// reserve bit clear means flexible
	assign dedicated = cfg_reg[CFG_RESERVE_BIT];
	assign trst_mode = cfg_reg[CFG_TRST_BIT];
	assign powered = good_sync_reg[1];

	// synchronisers for pin inputs
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			trst_sync_reg <= 2'h3;
			good_sync_reg <= 2'h0;
			tdo_sync_reg <= 2'h0;
			uin_meta_reg <= '0;
			uin_reg <= '0;
		end else begin
			trst_sync_reg <= {trst_sync_reg[0], PIN_IN[PIN_TRST]};
			good_sync_reg <= {good_sync_reg[0], SUPPLY_GOOD};
			tdo_sync_reg <= {tdo_sync_reg[0], SCAN_TDO};
			uin_meta_reg <= PIN_IN;
			uin_reg <= uin_meta_reg;
		end
	end

	// low test reset in reset mode
	assign trst_active = trst_mode & ~trst_sync_reg[1];

	tck_sampler u_sampler (
		.clk(CLK),
		.rst_b(RST_B),
		.tck_pin(PIN_IN[PIN_TCK]),
		.tms_pin(TMS_IN),
		.tdi_pin(PIN_IN[PIN_TDI]),
		.edges(edges)
	);

	tap_fsm u_tap (
		.clk(CLK),
		.rst_b(RST_B),
		.trst_active(trst_active),
		.edges(edges),
		.state(tap_state)
	);

	// ownership of shared pins
	// rise with tms low claims pins
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			scan_own_reg <= 1'b0;
		end else if (dedicated) begin
			scan_own_reg <= 1'b1;
		end else if (edges.tck_rise && !edges.tms_s) begin
			scan_own_reg <= 1'b1;
		end else if (tap_state == TLR) begin
			scan_own_reg <= 1'b0;
		end
	end

	// pin drive selection
	always_comb begin
		out_next = uout_reg;
		oe_next = uoe_reg;
		if (scan_own_reg) begin
			oe_next[PIN_TDI] = 1'b0;
			oe_next[PIN_TCK] = 1'b0;
			out_next[PIN_TDI] = 1'b0;
			out_next[PIN_TCK] = 1'b0;
			out_next[PIN_TDO] = tdo_sync_reg[1];
			oe_next[PIN_TDO] = (tap_state == SHIFT_DR) || (tap_state == SHIFT_IR);
		end
		if (trst_mode) begin
			oe_next[PIN_TRST] = 1'b0;
			out_next[PIN_TRST] = 1'b0;
		end
		if (!powered) begin
			oe_next = '0;
		end
	end

	// registered pin and pull outputs
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			PIN_OUT <= '0;
			PIN_OE <= '0;
			TMS_PULLUP <= 1'b0;
			TDI_PULLUP <= 1'b0;
			TRST_PULLUP <= 1'b0;
			PIN_PULLUP <= '0;
			PIN_PULLDN <= '0;
			SCAN_ACTIVE <= 1'b0;
		end else begin
			PIN_OUT <= out_next;
			PIN_OE <= oe_next;
			TMS_PULLUP <= dedicated;
			TDI_PULLUP <= dedicated;
			TRST_PULLUP <= trst_mode;
			PIN_PULLUP <= (!powered && cfg_reg[CFG_PULLUP_BIT]) ? {NPINS{1'b1}} : '0;
			PIN_PULLDN <= (!powered && cfg_reg[CFG_PULLDN_BIT] && !cfg_reg[CFG_PULLUP_BIT])
				? {NPINS{1'b1}} : '0;
			SCAN_ACTIVE <= scan_own_reg;
		end
	end

	// apb slave, zero wait states
	assign apb_access = PSEL && PENABLE;
	always_comb begin
		case (PADDR[11:0])
			CFG_OFFSET, STATUS_OFFSET, USER_OUT_OFFSET, USER_OE_OFFSET,
			USER_IN_OFFSET: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// writable registers
	// user pins tristated by default
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			cfg_reg <= CFG_RESET;
			uout_reg <= '0;
			uoe_reg <= '0;
		end else if (apb_access && PWRITE) begin
			case (PADDR[11:0])
				CFG_OFFSET: cfg_reg <= PWDATA[3:0];
				USER_OUT_OFFSET: uout_reg <= PWDATA[NPINS-1:0];
				USER_OE_OFFSET: uoe_reg <= PWDATA[NPINS-1:0];
				default: cfg_reg <= cfg_reg;
			endcase
		end
	end

	// read data and response
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			PRDATA <= 32'h0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !addr_ok;
			PRDATA <= 32'h0;
			if (PSEL && !PENABLE && !PWRITE) begin
				case (PADDR[11:0])
					CFG_OFFSET: PRDATA <= {28'h0, cfg_reg};
					STATUS_OFFSET: PRDATA <= {26'h0, powered, scan_own_reg, tap_state};
					USER_OUT_OFFSET: PRDATA <= {28'h0, uout_reg};
					USER_OE_OFFSET: PRDATA <= {28'h0, uoe_reg};
					USER_IN_OFFSET: PRDATA <= {28'h0, uin_reg};
					default: PRDATA <= 32'h0;
				endcase
			end
		end
	end

	// consecutive tck rises with tms high, saturating at the reset count
	// tms high rise count
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			tms_high_cnt <= 3'h0;
		end else if (edges.tck_rise) begin
			if (!edges.tms_s) begin
				tms_high_cnt <= 3'h0;
			end else if (tms_high_cnt != 3'(TMS_RESET_CYCLES)) begin
				tms_high_cnt <= tms_high_cnt + 3'h1;
			end
		end
	end

	// assertions
	// a_float_ramp: no drive while unpowered
	a_float_ramp: assert property (@(posedge CLK) disable iff (!RST_B)
		!$past(powered) |-> PIN_OE == '0) else $error("pin driven during ramp");
	a_flex_pulls: assert property (@(posedge CLK) disable iff (!RST_B)
		!$past(dedicated) |-> !TMS_PULLUP && !TDI_PULLUP) else $error("pull in flexible");
	a_ded_pulls: assert property (@(posedge CLK) disable iff (!RST_B)
		$past(dedicated) |-> TMS_PULLUP && TDI_PULLUP) else $error("no pull in dedicated");
	a_ded_owns: assert property (@(posedge CLK) disable iff (!RST_B)
		dedicated |=> scan_own_reg) else $error("dedicated lost pins");
	a_claim_pins: assert property (@(posedge CLK) disable iff (!RST_B)
		edges.tck_rise && !edges.tms_s |=> scan_own_reg) else $error("pins not claimed");
	a_release_tlr: assert property (@(posedge CLK) disable iff (!RST_B)
		!dedicated && tap_state == TLR && !edges.tck_rise |=> !scan_own_reg)
		else $error("pins not released");
	a_trst_reset: assert property (@(posedge CLK) disable iff (!RST_B)
		trst_active |=> tap_state == TLR) else $error("trst ignored");
	a_five_high: assert property (@(posedge CLK) disable iff (!RST_B)
		tms_high_cnt == 3'(TMS_RESET_CYCLES) |-> tap_state == TLR)
		else $error("no logic reset after tms high");
	a_trst_input: assert property (@(posedge CLK) disable iff (!RST_B)
		$past(trst_mode) |-> !PIN_OE[PIN_TRST] && TRST_PULLUP) else $error("trst driven");
	a_tck_input: assert property (@(posedge CLK) disable iff (!RST_B)
		$past(scan_own_reg) |-> !PIN_OE[PIN_TCK] && !PIN_OE[PIN_TDI]) else $error("tck driven");
	c_claim: cover property (@(posedge CLK) disable iff (!RST_B) $rose(scan_own_reg));
	c_release: cover property (@(posedge CLK) disable iff (!RST_B) $fell(scan_own_reg));
	c_shift: cover property (@(posedge CLK) disable iff (!RST_B) tap_state == SHIFT_DR);
	c_trst: cover property (@(posedge CLK) disable iff (!RST_B) trst_active);
endmodule : scan_pin_mode_control
`default_nettype wire

/* File: rtl/dummy_unused.sv */
`default_nettype none
`default_nettype wire

/* File: verification/jtag_host.sv */
`default_nettype none
module jtag_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_b
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: clock still, mode-select pulled high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_b = 1'b1;
	end
	// one 125 ns clock period, mode-select set before the rise
	// sampled on rise
	task automatic tick(input logic tms_val);
		tms <= tms_val;
		tdi <= ~tdi;
		#62.5 tck <= 1'b1;
		#62.5 tck <= 1'b0;
	endtask : tick
	task automatic to_reset();
		repeat (5) tick(1'b1);
	endtask : to_reset
	task automatic set_trst(input logic level);
		trst_b <= level;
	endtask : set_trst
endmodule : jtag_host
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
module tb_top
	import scan_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sup = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwd = 32'h0;
	logic [31:0] rd;
	logic err;
	wire logic [3:0] p_out, p_oe, p_up, p_dn, p_in;
	wire logic tms_up, tdi_up, trst_up, scan, pready, pslverr, tck, tms, tdi, trst_b;
	wire logic [31:0] prdata;
	logic [17:0] tms_seq = 18'h19756;
	tap_state_type exp_seq [18] = '{RTI, SEL_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR,
		PAUSE_IR, EXIT2_IR, UPD_IR, SEL_DR, CAP_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		SHIFT_DR, EXIT1_DR, UPD_DR, RTI};
	int num_errors = 0;
	int check_count = 0;
	// wire level: device enable wins, undriven tdo shows inverse pattern
	assign p_in = (p_oe & p_out) | (~p_oe & {trst_b, ~p_out[2], tck, tdi});
	always #2.5 clk = ~clk;
	scan_pin_mode_control u_dut (.CLK(clk), .RST_B(rst_b), .SUPPLY_GOOD(sup), .PIN_IN(p_in),
		.PIN_OUT(p_out), .PIN_OE(p_oe), .TMS_IN(tms), .TMS_PULLUP(tms_up),
		.TDI_PULLUP(tdi_up), .TRST_PULLUP(trst_up), .PIN_PULLUP(p_up), .PIN_PULLDN(p_dn),
		.SCAN_ACTIVE(scan), .SCAN_TDO(1'b1), .PADDR(paddr), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		paddr <= {20'h0, a};
		pwr <= wr;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) check(32'h1, 32'h0);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : apb
	task automatic status();
		@(posedge clk);
		apb(1'b0, STATUS_OFFSET, 32'h0);
	endtask : status
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		#50000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, CFG_OFFSET, 32'h0);
		check(rd, 32'h0);
		status();
		check(rd[5:0], {2'b00, TLR});
		check({p_oe, p_up, p_dn}, 12'h0);
		check({tms_up, tdi_up, trst_up}, 3'h0);
		apb(1'b1, CFG_OFFSET, 32'hc);
		check({p_up, p_dn}, 8'hf0);
		apb(1'b1, CFG_OFFSET, 32'h8);
		check({p_up, p_dn}, 8'h0f);
		apb(1'b1, CFG_OFFSET, 32'h0);
		apb(1'b1, USER_OUT_OFFSET, 32'ha);
		apb(1'b1, USER_OE_OFFSET, 32'hf);
		sup <= 1'b1;
		repeat (8) @(posedge clk);
		check({p_oe, p_out, p_up, p_dn}, 16'hfa00);
		apb(1'b1, USER_OE_OFFSET, 32'h4);
		check(p_oe, 4'h4);
		apb(1'b0, USER_IN_OFFSET, 32'h0);
		check(rd, 32'h9);
		apb(1'b0, USER_OUT_OFFSET, 32'h0);
		check(rd, 32'ha);
		// walk every state of the test controller
		for (int i = 0; i < 18; i++) begin
			u_host.tick(tms_seq[17-i]);
			status();
			check(rd[5:0], {2'b11, exp_seq[i]});
			check({p_oe[2], scan}, {exp_seq[i] inside {SHIFT_DR, SHIFT_IR}, 1'b1});
			if (p_oe[2]) check(p_out[2], 1'b1);
		end
		u_host.to_reset();
		status();
		check({scan, p_oe[2], rd[4:0]}, {2'b01, 1'b0, TLR});
		// test reset pin forces logic-reset
		apb(1'b1, CFG_OFFSET, 32'h2);
		check(trst_up, 1'b1);
		u_host.tick(1'b0);
		status();
		check(rd[4:0], {1'b1, RTI});
		u_host.set_trst(1'b0);
		repeat (8) @(posedge clk);
		status();
		check({scan, rd[4:0]}, {1'b0, 1'b0, TLR});
		u_host.set_trst(1'b1);
		// dedicated mode keeps every scan pin
		apb(1'b1, CFG_OFFSET, 32'h1);
		check({tms_up, tdi_up, scan, p_oe[2]}, 4'he);
		apb(1'b0, 12'h014, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		sup <= 1'b0;
		repeat (6) @(posedge clk);
		check(p_oe, 4'h0);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
